// ### cmss_regs.vh
// constants for the machine-state sequencer: states, cycle phases, bus map
// assumes includers use these names only; no logic lives here
`ifndef CMSS_REGS_VH
`define CMSS_REGS_VH

// machine state codes driven on the state-code outputs
`define CMSS_S0          2'h0
`define CMSS_S1          2'h1
`define CMSS_S2          2'h2
`define CMSS_S3          2'h3

// one machine cycle is eight clocks
`define CMSS_PH_W        3
`define CMSS_PH_DRIVE    3'h1
`define CMSS_PH_STB_OFF  3'h6
`define CMSS_PH_LAST     3'h7

// interrupt entry selector values, mark register index and reset values
`define CMSS_INT_P       4'h1
`define CMSS_INT_X       4'h2
`define CMSS_MARK_REG    4'h2
`define CMSS_RST_IE      1'b1

// wishbone register byte offsets
`define CMSS_OFF_CTRL    4'h0
`define CMSS_OFF_STATUS  4'h4

// control register fields
`define CMSS_CTRL_HOLD   0

// pin synchroniser reset value: clear and wait idle high
`define CMSS_PIN_RST     13'h1800

`endif

// ### cmss_regfile.v
// sixteen 16-bit scratch registers, one write port, one registered read port
// assumes read address is held stable for a whole machine cycle
`timescale 1ns/1ps
module cmss_regfile (
	input  wire        clk_i,
	input  wire        we_i,
	input  wire [3:0]  waddr_i,
	input  wire [15:0] wdata_i,
	input  wire [3:0]  raddr_i,
	output reg  [15:0] rdata_o
);
	reg [15:0] mem [0:15];

	// contents are left unset; the init cycle clears register 0 only
	always @(posedge clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
		rdata_o <= mem[raddr_i];
	end
endmodule

// ### cmss_sequencer.v
// machine-state sequencer and bus-cycle controller of an 8-bit cpu core
// assumes memory answers within two clocks of the address; pins are async
// Overview of operation
// - dma-in: address r0 (r0-1 in load mode), write strobe low, device supplies bus, r0 increments
// - simultaneous dma requests: inbound transfer served first
// - interrupt cycle: save x,p to t, clear mask, p=1, x=2, no strobes
// - every fetch cycle is followed by an execute cycle
// - reset: mask enabled, timing pulses suppressed, state code execute
// - init cycle clearing r0 drives bus to zero whole cycle
// - load mode: idle reading r0-1, no address pulse, await dma
// - idle instruction repeats execute cycles until dma or interrupt
// - returns load x,p from m(rx), bump rx; one enables, one clears mask
// - output control sets or clears q; bus floats, no strobes
// - plain right shift: lsb to carry, msb cleared, no memory access
// - register byte transfers move bytes without memory strobes
// - taken long branch: latch byte, bump pc, then load pc from latch+memory
// - taken long skip bumps pc in both read cycles; untaken does nothing
// - add with carry: m(rx)+d+carry into carry and accumulator
// - immediate ops read operand at pc, combine, bump pc
// - only arithmetic and shifts alter carry; after subtract one means no borrow
//
// The register offsets and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ps
`include "cmss_regs.vh"
module cmss_sequencer (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        clear_n_i,
	input  wire        wait_n_i,
	input  wire        dma_in_req_i,
	input  wire        dma_out_req_i,
	input  wire        interrupt_req_i,
	input  wire [7:0]  bus_i,
	output reg  [7:0]  bus_o,
	output reg         bus_oe_o,
	output reg  [15:0] mem_addr_o,
	output reg         memory_read_strobe_n_o,
	output reg         memory_write_strobe_n_o,
	output reg         address_timing_pulse_o,
	output reg         late_timing_pulse_o,
	output reg  [1:0]  state_code_o,
	output reg         q_o,
	input  wire [3:0]  wb_adr_i,
	input  wire [31:0] wb_dat_i,
	input  wire [3:0]  wb_sel_i,
	input  wire        wb_we_i,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o
);
	reg [12:0] pin1_reg, pin2_reg, pin3_reg, pinf_reg;
	reg [2:0]  ph_reg;
	reg [1:0]  state_reg, state_next;
	reg [7:0]  instr_reg, instr_next, d_reg, d_next, t_reg, t_next, b_reg, b_next;
	reg        df_reg, df_next, ie_reg, ie_next, q_reg, q_next;
	reg [3:0]  x_reg, x_next, p_reg, p_next;
	reg        init_reg, load_reg, load_next, exec2_reg, exec2_next;
	reg        dmain_reg, hold_reg;
	reg        rf_we;
	reg [15:0] rf_wdata;
	reg        rd_n_c, wr_n_c, oe_c;
	reg [7:0]  bv_c;

	// pin n changes only once stages two and three agree
	wire       clear_f = pinf_reg[12];
	wire       wait_f  = pinf_reg[11];
	wire       din     = pinf_reg[10];
	wire       dout    = pinf_reg[9];
	wire       irq     = pinf_reg[8];
	wire [7:0] md      = pinf_reg[7:0];

	wire [3:0]  hi = instr_reg[7:4];
	wire [3:0]  lo = instr_reg[3:0];
	wire [15:0] rf_rdata;
	wire        zero_idx = (state_reg == `CMSS_S2) |
		((state_reg == `CMSS_S1) & (init_reg | load_reg));
	wire [3:0]  rf_idx = cmss_idx(state_reg, instr_reg, x_reg, p_reg, zero_idx);
	wire [15:0] rf_inc = rf_rdata + 16'h0001;
	wire [15:0] rf_dec = rf_rdata - 16'h0001;
	wire        ph_adv = ~(hold_reg & (ph_reg == 3'h0));
	wire        run_s1 = (state_reg == `CMSS_S1) & ~init_reg & ~load_reg;
	// register writes land once per machine cycle, only where the cycle really ends
	wire        rf_we_g = rf_we & (ph_reg == `CMSS_PH_LAST) & ~rst_i &
		(clear_f | (~wait_f & load_reg));

	wire        cnd = cmss_cond(lo[1:0], q_reg, d_reg, df_reg);
	wire        br_take = lo[3] ? ~cnd : cnd;
	wire        sk_take = (lo == 4'h4) ? 1'b0 :
		lo[3] ? ((lo[1:0] == 2'h0) ? ie_reg : cnd) : ~cnd;
	wire [8:0]  alu_r = cmss_alu(lo[2:0], md, d_reg, df_reg, hi == 4'h7);

	// dma before interrupt; in load mode only dma leaves the idle cycle
	wire [1:0]  gen_state = (din | dout) ? `CMSS_S2 :
		load_next ? `CMSS_S1 :
		(irq & ie_reg) ? `CMSS_S3 : `CMSS_S0;

	function [3:0] cmss_idx(input [1:0] st, input [7:0] ins,
		input [3:0] xs, input [3:0] ps, input zero);
		begin
			if (zero) begin
				cmss_idx = 4'h0;
			end else if (st != `CMSS_S1) begin
				cmss_idx = ps;
			end else if (ins[7:4] == 4'h7) begin
				cmss_idx = (ins[3:0] <= 4'h8) ? xs :
					(ins[3:0] == 4'h9) ? `CMSS_MARK_REG : ps;
			end else if (ins[7:4] == 4'hc) begin
				cmss_idx = ps;
			end else if (ins[7:4] == 4'hf) begin
				cmss_idx = ins[3] ? ps : xs;
			end else begin
				cmss_idx = ins[3:0];
			end
		end
	endfunction

	function cmss_cond(input [1:0] sel, input qv, input [7:0] dv, input cv);
		begin
			case (sel)
				2'h0: cmss_cond = 1'b1;
				2'h1: cmss_cond = qv;
				2'h2: cmss_cond = (dv == 8'h00);
				default: cmss_cond = cv;
			endcase
		end
	endfunction

	// subtracts add the complement so carry out reads as no-borrow
	function [8:0] cmss_alu(input [2:0] op, input [7:0] m, input [7:0] a,
		input c, input usec);
		begin
			case (op)
				3'h1: cmss_alu = {c, m | a};
				3'h2: cmss_alu = {c, m & a};
				3'h3: cmss_alu = {c, m ^ a};
				3'h4: cmss_alu = {1'b0, m} + {1'b0, a} + {8'h00, usec & c};
				3'h5: cmss_alu = {1'b0, m} + {1'b0, ~a} + {8'h00, ~usec | c};
				3'h7: cmss_alu = {1'b0, a} + {1'b0, ~m} + {8'h00, ~usec | c};
				default: cmss_alu = {c, m};
			endcase
		end
	endfunction

	cmss_regfile u_rf (
		.clk_i   (clk_i),
		.we_i    (rf_we_g),
		.waddr_i (rf_idx),
		.wdata_i (rf_wdata),
		.raddr_i (rf_idx),
		.rdata_o (rf_rdata)
	);

	// strobe and bus decode for the cycle in progress
	always @* begin
		rd_n_c = 1'b1;
		wr_n_c = 1'b1;
		oe_c = 1'b0;
		bv_c = 8'h00;
		case (state_reg)
			`CMSS_S0: rd_n_c = 1'b0;
			`CMSS_S2: begin
				rd_n_c = dmain_reg;
				wr_n_c = ~dmain_reg;
			end
			`CMSS_S1: begin
				if (init_reg) begin
					oe_c = 1'b1;
				end else if (load_reg) begin
					rd_n_c = 1'b0;
				end else begin
					case (hi)
						4'h7: begin
							if (lo == 4'h3 || lo == 4'h8 || lo == 4'h9) begin
								wr_n_c = 1'b0;
								oe_c = 1'b1;
								bv_c = (lo == 4'h3) ? d_reg :
									(lo == 4'h8) ? t_reg : {x_reg, p_reg};
							end else if (lo != 4'h6 && lo != 4'ha &&
								lo != 4'hb && lo != 4'he) begin
								rd_n_c = 1'b0;
							end
						end
						4'h8, 4'h9: begin
							oe_c = 1'b1;
							bv_c = hi[0] ? rf_rdata[15:8] : rf_rdata[7:0];
						end
						4'ha, 4'hb: begin
							oe_c = 1'b1;
							bv_c = d_reg;
						end
						4'hd, 4'he: begin
							oe_c = 1'b1;
							bv_c = {lo, lo};
						end
						4'hf: rd_n_c = lo[2:0] == 3'h6;
						4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6: rd_n_c = 1'b1;
						default: rd_n_c = 1'b0;
					endcase
				end
			end
			default: rd_n_c = 1'b1;
		endcase
	end

	// end-of-cycle register transfers and next machine state
	always @* begin
		d_next = d_reg;
		df_next = df_reg;
		ie_next = ie_reg;
		q_next = q_reg;
		x_next = x_reg;
		p_next = p_reg;
		t_next = t_reg;
		b_next = b_reg;
		instr_next = instr_reg;
		exec2_next = 1'b0;
		load_next = load_reg & ~clear_f;
		rf_we = 1'b0;
		rf_wdata = rf_inc;
		state_next = gen_state;
		case (state_reg)
			`CMSS_S0: begin
				instr_next = md;
				rf_we = 1'b1;
				state_next = `CMSS_S1;
			end
			`CMSS_S2: rf_we = 1'b1;
			`CMSS_S3: begin
				t_next = {x_reg, p_reg};
				ie_next = 1'b0;
				p_next = `CMSS_INT_P;
				x_next = `CMSS_INT_X;
			end
			default: begin
				if (init_reg) begin
					rf_we = 1'b1;
					rf_wdata = 16'h0000;
				end else if (run_s1) begin
					case (hi)
						4'h0: begin
							if (lo == 4'h0 && gen_state == `CMSS_S0) begin
								state_next = `CMSS_S1;
							end
						end
						4'h7: begin
							case (lo)
								4'h0, 4'h1: begin
									x_next = md[7:4];
									p_next = md[3:0];
									ie_next = ~lo[0];
									rf_we = 1'b1;
								end
								4'h2: begin
									d_next = md;
									rf_we = 1'b1;
								end
								4'h3: begin
									rf_we = 1'b1;
									rf_wdata = rf_dec;
								end
								4'h6: begin
									df_next = d_reg[0];
									d_next = {df_reg, d_reg[7:1]};
								end
								4'he: begin
									df_next = d_reg[7];
									d_next = {d_reg[6:0], df_reg};
								end
								4'h8: rf_we = 1'b0;
								4'h9: begin
									t_next = {x_reg, p_reg};
									x_next = p_reg;
									rf_we = 1'b1;
									rf_wdata = rf_dec;
								end
								4'ha, 4'hb: q_next = lo[0];
								default: begin
									{df_next, d_next} = alu_r;
									rf_we = lo[3];
								end
							endcase
						end
						4'h8: d_next = rf_rdata[7:0];
						4'h9: d_next = rf_rdata[15:8];
						4'ha, 4'hb: begin
							rf_we = 1'b1;
							rf_wdata = hi[0] ? {d_reg, rf_rdata[7:0]} :
								{rf_rdata[15:8], d_reg};
						end
						4'hc: begin
							if (~exec2_reg) begin
								exec2_next = 1'b1;
								state_next = `CMSS_S1;
								if (~lo[2] & br_take) begin
									b_next = md;
								end
							end else if (~lo[2] & br_take) begin
								rf_wdata = {b_reg, md};
							end
							rf_we = lo[2] ? sk_take : 1'b1;
						end
						4'hd: p_next = lo;
						4'he: x_next = lo;
						4'hf: begin
							if (lo[2:0] == 3'h6) begin
								df_next = lo[3] ? d_reg[7] : d_reg[0];
								d_next = lo[3] ? {d_reg[6:0], 1'b0} : {1'b0, d_reg[7:1]};
							end else begin
								{df_next, d_next} = alu_r;
								rf_we = lo[3];
							end
						end
						default: rf_we = 1'b0;
					endcase
				end
			end
		endcase
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			pin1_reg <= `CMSS_PIN_RST;
			pin2_reg <= `CMSS_PIN_RST;
			pin3_reg <= `CMSS_PIN_RST;
			pinf_reg <= `CMSS_PIN_RST;
		end else begin
			pin1_reg <= {clear_n_i, wait_n_i, dma_in_req_i, dma_out_req_i,
				interrupt_req_i, bus_i};
			pin2_reg <= pin1_reg;
			pin3_reg <= pin2_reg;
			pinf_reg <= (pin2_reg & pin3_reg) | (pinf_reg & (pin2_reg | pin3_reg));
		end
	end

	always @(posedge clk_i) begin
		if (rst_i | (~clear_f & wait_f)) begin
			ph_reg <= 3'h0;
			state_reg <= `CMSS_S1;
			state_code_o <= `CMSS_S1;
			ie_reg <= `CMSS_RST_IE;
			q_reg <= 1'b0;
			q_o <= 1'b0;
			x_reg <= 4'h0;
			p_reg <= 4'h0;
			instr_reg <= 8'h00;
			d_reg <= 8'h00;
			df_reg <= 1'b0;
			t_reg <= 8'h00;
			b_reg <= 8'h00;
			init_reg <= 1'b1;
			load_reg <= 1'b0;
			exec2_reg <= 1'b0;
			dmain_reg <= 1'b0;
			address_timing_pulse_o <= 1'b0;
			late_timing_pulse_o <= 1'b0;
			memory_read_strobe_n_o <= 1'b1;
			memory_write_strobe_n_o <= 1'b1;
			bus_o <= 8'h00;
			bus_oe_o <= 1'b1;
			mem_addr_o <= 16'h0000;
		end else if (~clear_f & ~wait_f & ~load_reg) begin
			load_reg <= 1'b1;
			init_reg <= 1'b0;
			state_reg <= `CMSS_S1;
			state_code_o <= `CMSS_S1;
			ph_reg <= 3'h0;
			address_timing_pulse_o <= 1'b0;
			late_timing_pulse_o <= 1'b0;
			memory_read_strobe_n_o <= 1'b1;
			memory_write_strobe_n_o <= 1'b1;
			bus_oe_o <= 1'b0;
		end else begin
			if (ph_adv) begin
				ph_reg <= ph_reg + 3'h1;
			end
			address_timing_pulse_o <= (ph_reg == `CMSS_PH_DRIVE) & ~load_reg;
			late_timing_pulse_o <= ph_reg == `CMSS_PH_STB_OFF;
			if (ph_reg == `CMSS_PH_DRIVE) begin
				mem_addr_o <= load_reg ? rf_dec : rf_rdata;
				memory_read_strobe_n_o <= rd_n_c;
				memory_write_strobe_n_o <= wr_n_c;
				bus_o <= bv_c;
				bus_oe_o <= oe_c;
			end
			// strobes end a clock early so written data outlives them
			if (ph_reg == `CMSS_PH_STB_OFF) begin
				memory_read_strobe_n_o <= 1'b1;
				memory_write_strobe_n_o <= 1'b1;
			end
			if (ph_reg == `CMSS_PH_LAST) begin
				bus_oe_o <= 1'b0;
				state_reg <= state_next;
				state_code_o <= state_next;
				instr_reg <= instr_next;
				d_reg <= d_next;
				df_reg <= df_next;
				ie_reg <= ie_next;
				q_reg <= q_next;
				q_o <= q_next;
				x_reg <= x_next;
				p_reg <= p_next;
				t_reg <= t_next;
				b_reg <= b_next;
				exec2_reg <= exec2_next;
				init_reg <= 1'b0;
				load_reg <= load_next;
				dmain_reg <= din;
			end
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
			hold_reg <= 1'b0;
		end else begin
			wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
			if (wb_cyc_i & wb_stb_i & ~wb_ack_o) begin
				if (wb_we_i) begin
					if (wb_adr_i == `CMSS_OFF_CTRL && wb_sel_i[0]) begin
						hold_reg <= wb_dat_i[`CMSS_CTRL_HOLD];
					end
					wb_dat_o <= 32'h00000000;
				end else if (wb_adr_i == `CMSS_OFF_CTRL) begin
					wb_dat_o <= {31'h00000000, hold_reg};
				end else if (wb_adr_i == `CMSS_OFF_STATUS) begin
					wb_dat_o <= {10'h000, state_reg, x_reg, p_reg,
						load_reg, q_reg, ie_reg, df_reg, d_reg};
				end else begin
					wb_dat_o <= 32'h00000000;
				end
			end
		end
	end
endmodule

// ### cmss_chk_assertions.sv
// pin-level checks on the machine-state sequencer
// assumes one clock domain and the synchronous active-high reset
`timescale 1ns/1ps
module cmss_chk (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_ack_o,
	input wire logic [7:0]  bus_o,
	input wire logic        bus_oe_o,
	input wire logic [15:0] mem_addr_o,
	input wire logic        memory_read_strobe_n_o,
	input wire logic        memory_write_strobe_n_o,
	input wire logic        address_timing_pulse_o,
	input wire logic        late_timing_pulse_o,
	input wire logic [1:0]  state_code_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// reset itself is the cause here, so it must not disable the check
	chk_reset_values: assert property (disable iff (1'b0) rst_i |=> state_code_o == 2'h1 &&
		!address_timing_pulse_o && !late_timing_pulse_o && bus_oe_o && bus_o == 8'h00)
		else $error("outputs wrong during reset");
	chk_no_dual_strobe: assert property (memory_read_strobe_n_o || memory_write_strobe_n_o)
		else $error("both strobes low");
	chk_read_span: assert property ($fell(memory_read_strobe_n_o) |=>
		(!memory_read_strobe_n_o && $stable(mem_addr_o))[*4] ##1 memory_read_strobe_n_o)
		else $error("read strobe span wrong");
	chk_write_span: assert property ($fell(memory_write_strobe_n_o) |=>
		(!memory_write_strobe_n_o && $stable(mem_addr_o))[*4] ##1 memory_write_strobe_n_o)
		else $error("write strobe span wrong");
	chk_fetch_then_exec: assert property (state_code_o == 2'h0 && late_timing_pulse_o |=>
		state_code_o == 2'h1) else $error("fetch not followed by execute");
	chk_pulse_spacing: assert property (address_timing_pulse_o |=>
		!address_timing_pulse_o ##4 late_timing_pulse_o) else $error("timing pulse spacing");
	chk_int_float: assert property (state_code_o == 2'h3 && address_timing_pulse_o |->
		memory_read_strobe_n_o && memory_write_strobe_n_o && !bus_oe_o)
		else $error("interrupt cycle accesses memory");
	chk_dma_in_dir: assert property (state_code_o == 2'h2 && !memory_write_strobe_n_o |->
		memory_read_strobe_n_o && !bus_oe_o) else $error("dma in drives bus");
	chk_dma_out_dir: assert property (state_code_o == 2'h2 && !memory_read_strobe_n_o |->
		!bus_oe_o) else $error("dma out drives bus");
	chk_store_drives: assert property (state_code_o == 2'h1 && !memory_write_strobe_n_o |->
		bus_oe_o) else $error("store leaves bus floating");
	chk_wb_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus answer timing");
	cov_dma_in: cover property (state_code_o == 2'h2 && !memory_write_strobe_n_o);
	cov_dma_out: cover property (state_code_o == 2'h2 && !memory_read_strobe_n_o);
	cov_interrupt: cover property (state_code_o == 2'h3);
endmodule

bind cmss_sequencer cmss_chk u_chk (.*);

// ### cmss_mem_model.sv
// memory plus dma device facing the sequencer's memory pins
// assumes address stands for the whole cycle; data valid one clock after
`timescale 1ns/1ps
module cmss_mem_model (
	input  wire logic        clk_i,
	input  wire logic [15:0] addr_i,
	input  wire logic        rd_n_i,
	input  wire logic        wr_n_i,
	input  wire logic        oe_i,
	input  wire logic [7:0]  cpu_data_i,
	input  wire logic [7:0]  dma_data_i,
	output logic      [7:0]  data_o
);
	logic [7:0]  mem [0:65535];
	logic [15:0] addr_q;
	logic        rd_act;
	logic        wr_act;
	initial begin
		data_o = 8'h00;
		addr_q = 16'h0000;
		rd_act = 1'b0;
		wr_act = 1'b0;
		for (int i = 0; i < 65536; i++)
			mem[i] = 8'h00;
	end
	// data held until the address moves; released bus flips every clock
	always @(posedge clk_i) begin
		addr_q <= addr_i;
		rd_act <= !rd_n_i || (rd_act && addr_i == addr_q);
		wr_act <= (!wr_n_i && !oe_i) || (wr_act && addr_i == addr_q);
		if (!rd_n_i || rd_act)
			data_o <= mem[addr_i];
		else if (wr_act)
			data_o <= dma_data_i;
		else
			data_o <= ~data_o;
		if (!wr_n_i)
			mem[addr_i] <= oe_i ? cpu_data_i : dma_data_i;
	end
endmodule

// ### tb.sv
// bench: short program, dma in and out, interrupt, status over wishbone
// assumes the memory model's array is reachable as mem.mem
`timescale 1ns/1ps
module tb;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        dma_in = 1'b0;
	logic        dma_out = 1'b0;
	logic        irq = 1'b0;
	logic [3:0]  wb_adr = 4'h0;
	logic [31:0] wb_wd = 32'h0;
	logic        wb_we = 1'b0;
	logic        wb_cyc = 1'b0;
	logic        wb_stb = 1'b0;
	logic [31:0] wb_rd;
	logic        wb_ack;
	logic [7:0]  bus_i;
	logic [7:0]  bus_o;
	logic        oe, rd_n, wr_n, atp, ltp, q;
	logic [15:0] addr;
	logic [1:0]  sc;
	logic [31:0] st;
	int          bad;
	int          num_errors = 0;
	int          n_compared = 0;
	logic [7:0]  prog [0:19] = '{8'hf8, 8'h40, 8'ha1, 8'hf8, 8'h00, 8'hb1, 8'hf8, 8'h55,
		8'hf6, 8'h7b, 8'hfb, 8'h0f, 8'hb2, 8'hf8, 8'h60, 8'ha2, 8'he2, 8'h73, 8'h82, 8'h00};

	always #5 clk_i = ~clk_i;

	cmss_sequencer DUT (.clk_i(clk_i), .rst_i(rst_i), .clear_n_i(1'b1), .wait_n_i(1'b1),
		.dma_in_req_i(dma_in), .dma_out_req_i(dma_out), .interrupt_req_i(irq), .bus_i(bus_i),
		.bus_o(bus_o), .bus_oe_o(oe), .mem_addr_o(addr), .memory_read_strobe_n_o(rd_n),
		.memory_write_strobe_n_o(wr_n), .address_timing_pulse_o(atp),
		.late_timing_pulse_o(ltp), .state_code_o(sc), .q_o(q), .wb_adr_i(wb_adr),
		.wb_dat_i(wb_wd), .wb_sel_i(4'hf), .wb_we_i(wb_we), .wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_stb), .wb_dat_o(wb_rd), .wb_ack_o(wb_ack));
	cmss_mem_model mem (.clk_i(clk_i), .addr_i(addr), .rd_n_i(rd_n), .wr_n_i(wr_n),
		.oe_i(oe), .cpu_data_i(bus_o), .dma_data_i(8'ha7), .data_o(bus_i));

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		wb_adr <= a;
		wb_we <= w;
		wb_wd <= d;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		@(posedge clk_i);
		while (wb_ack !== 1'b1 && n < 20) begin
			n++;
			@(posedge clk_i);
		end
		if (n >= 20)
			num_errors++;
		st = wb_rd;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic wait_sc(input logic [1:0] v, input logic stb);
		int n;
		n = 0;
		while (!(sc === v && (!stb || rd_n === 1'b0 || wr_n === 1'b0)) && n < 300) begin
			n++;
			@(posedge clk_i);
		end
		cmp(n < 300, 1'b1);
	endtask

	task automatic close_out();
		$display("compared %0d, mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// the whole run needs under 2000 cycles
	initial begin
		#100000;
		num_errors++;
		close_out();
	end

	initial begin
		#1;
		for (int i = 0; i < 20; i++)
			mem.mem[i] = prog[i];
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (600) @(posedge clk_i);
		wb(4'h4, 1'b0, 32'h0);
		cmp(st[19:0], 20'h2075f);
		cmp(st[8], 1'b1);
		cmp(mem.mem[16'h2560], 8'h60);
		cmp(q, 1'b1);
		dma_in <= 1'b1;
		dma_out <= 1'b1;
		wait_sc(2'h2, 1'b1);
		cmp(wr_n, 1'b0);
		dma_in <= 1'b0;
		dma_out <= 1'b0;
		repeat (40) @(posedge clk_i);
		cmp(mem.mem[16'h0014], 8'ha7);
		dma_out <= 1'b1;
		wait_sc(2'h2, 1'b1);
		cmp(rd_n, 1'b0);
		dma_out <= 1'b0;
		repeat (40) @(posedge clk_i);
		irq <= 1'b1;
		wait_sc(2'h3, 1'b0);
		irq <= 1'b0;
		repeat (40) @(posedge clk_i);
		wb(4'h4, 1'b0, 32'h0);
		cmp(st[19:0], 20'h2155f);
		irq <= 1'b1;
		bad = 0;
		repeat (100) begin
			@(posedge clk_i);
			if (sc === 2'h3)
				bad++;
		end
		irq <= 1'b0;
		cmp(bad, 0);
		wb(4'h8, 1'b1, 32'hffffffff);
		wb(4'h8, 1'b0, 32'h0);
		cmp(st, 32'h0);
		wb(4'h0, 1'b1, 32'h0);
		close_out();
	end
endmodule
